// *** hdl/ppps_top.sv ***
// Pad role selection, slave buffer status and dual-buffer write addressing for the parallel port
//
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ns
`include "ppps_params.svh"
module ppps_top (
  input wire logic clock,
  input wire logic resetn,
  input wire ppps_pkg::ppps_bus_req_type bus_req,
  output logic [31:0] bus_rdata,
  input wire ppps_pkg::ppps_host_req_type host_req,
  output logic [7:0] host_rdata,
  output logic [15:0] port_address_line_out,
  output logic [15:0] port_address_line_oe,
  output logic [15:0] general_io_owned,
  output logic [15:0] port_data_out,
  output logic port_write_strobe,
  output logic port_busy
);
  import ppps_pkg::*;

  // Reset release through two flip-flops
  logic rst_meta_reg;
  logic rst_n;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // Word compare on the register port
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // Software registers
  logic [15:0] pin_enable_reg;  // Pad role enables
  logic [15:0] write_target_addr_reg;       // Write target address
  logic [15:0] raddr_reg;       // Read target address
  logic [15:0] shared_addr_reg; // Address used without dual buffering
  logic [31:0] control_reg;     // Main control fields
  logic [15:0] data_out_reg;    // Output data register
  logic [15:0] pad_addr_reg;    // Address presented on the pads
  logic [31:0] rdata_reg;       // Read data, one cycle after the strobe
  logic [7:0] host_rdata_reg;   // Byte returned to the host

  // Slave buffers and flags
  logic [7:0] in_buf_reg [4];
  logic [7:0] out_buf_reg [4];
  logic [3:0] in_full_reg;
  logic [3:0] out_empty_reg;
  logic overflow_reg;
  logic underflow_reg;
  ppps_state_type state_reg;

  // Control field decode
  wire [1:0] chip_select_function = control_reg[`PPPS_CSF_HI:`PPPS_CSF_LO];
  wire [1:0] address_data_multiplex = control_reg[`PPPS_ADDRESS_DATA_MULTIPLEX_HI:`PPPS_ADDRESS_DATA_MULTIPLEX_LO];
  wire slave_mode = control_reg[`PPPS_SLAVE_BIT];
  wire sixteen_bit_width = control_reg[`PPPS_SIXTEEN_BIT_WIDTH_BIT];
  wire dual_buffer_enable = control_reg[`PPPS_DUAL_BUFFER_ENABLE_BIT];

  // Register port strobes
  wire wr_pin = bus_req.wr && hit(bus_req.addr, `PPPS_OFF_PIN_ENABLE);
  wire wr_status = bus_req.wr && hit(bus_req.addr, `PPPS_OFF_STATUS);
  wire wr_write_target_addr = bus_req.wr && hit(bus_req.addr, `PPPS_OFF_WRITE_TARGET_ADDR);
  wire wr_control = bus_req.wr && hit(bus_req.addr, `PPPS_OFF_CONTROL);
  wire wr_raddr = bus_req.wr && hit(bus_req.addr, `PPPS_OFF_RADDR);
  wire wr_shared = bus_req.wr && hit(bus_req.addr, `PPPS_OFF_SHARED_ADDR);
  wire wr_data = bus_req.wr && hit(bus_req.addr, `PPPS_OFF_DATA_OUT);
  wire [1:0] buf_idx = bus_req.addr[3:2];
  wire in_blk = ((bus_req.addr & `PPPS_BUF_BLOCK_MASK) == `PPPS_OFF_IN_BUF) && (bus_req.addr[1:0] == 2'h0);
  wire out_blk = ((bus_req.addr & `PPPS_BUF_BLOCK_MASK) == `PPPS_OFF_OUT_BUF) && (bus_req.addr[1:0] == 2'h0);
  wire [3:0] idx_onehot = 4'h1 << buf_idx;
  wire [3:0] sw_in_read = (bus_req.rd && in_blk) ? idx_onehot : 4'h0;
  wire [3:0] sw_out_write = (bus_req.wr && out_blk) ? idx_onehot : 4'h0;

  // Host strobes act only in slave mode
  wire [3:0] host_onehot = 4'h1 << host_req.idx;
  wire host_wr = host_req.wr && slave_mode;
  wire host_rd = host_req.rd && slave_mode;
  wire [3:0] host_fill = (host_wr && !in_full_reg[host_req.idx]) ? host_onehot : 4'h0;
  wire [3:0] host_take = (host_rd && !out_empty_reg[host_req.idx]) ? host_onehot : 4'h0;
  wire overflow_set = host_wr && in_full_reg[host_req.idx];
  wire underflow_set = host_rd && out_empty_reg[host_req.idx];

  // Flag next values; hardware set wins over software clear
  wire [3:0] in_full_next = host_fill | (in_full_reg & ~sw_in_read);
  wire [3:0] out_empty_next = host_take | (out_empty_reg & ~sw_out_write);
  wire overflow_next = overflow_set | (overflow_reg & ~(wr_status & ~bus_req.wdata[`PPPS_OVF_BIT]));
  wire underflow_next = underflow_set | (underflow_reg & ~(wr_status & ~bus_req.wdata[`PPPS_UNF_BIT]));
  wire input_all_full = &in_full_reg;
  wire output_all_empty = &out_empty_reg;

  // Status word layout
  wire [31:0] status_word = {16'h0000, input_all_full, overflow_reg, 2'h0, in_full_reg,
                             output_all_empty, underflow_reg, 2'h0, out_empty_reg};

  // Read mux, unmapped addresses read zero
  wire [31:0] rdata_next =
    hit(bus_req.addr, `PPPS_OFF_PIN_ENABLE) ? {16'h0000, pin_enable_reg} :
    hit(bus_req.addr, `PPPS_OFF_STATUS) ? status_word :
    hit(bus_req.addr, `PPPS_OFF_WRITE_TARGET_ADDR) ? {16'h0000, write_target_addr_reg} :
    hit(bus_req.addr, `PPPS_OFF_CONTROL) ? control_reg :
    hit(bus_req.addr, `PPPS_OFF_RADDR) ? {16'h0000, raddr_reg} :
    hit(bus_req.addr, `PPPS_OFF_SHARED_ADDR) ? {16'h0000, shared_addr_reg} :
    hit(bus_req.addr, `PPPS_OFF_DATA_OUT) ? {16'h0000, data_out_reg} :
    in_blk ? {24'h000000, in_buf_reg[buf_idx]} : 32'h00000000;

  // Transaction start: in dual buffer mode the data write lands on the MSB byte.
  // Without byte enables every word write covers both bytes, so a data write in dual buffer mode outside slave mode starts one when the sequence is in PPPS_IDLE.
  wire msb_written = sixteen_bit_width ? 1'b1 : 1'b1;
  wire start_write = wr_data && dual_buffer_enable && msb_written && !slave_mode;
  wire [15:0] write_addr_src = dual_buffer_enable ? write_target_addr_reg : shared_addr_reg;
  wire [15:0] idle_addr_src = dual_buffer_enable ? raddr_reg : shared_addr_reg;

  // Top pad roles from chip-select field, bottom pad latch roles from the multiplex field
  wire cs2_role = (chip_select_function == `PPPS_CSF_CS2) || (chip_select_function == `PPPS_CSF_BOTH);
  wire cs1_role = (chip_select_function == `PPPS_CSF_BOTH);
  wire in_write = (state_reg == PPPS_WRITE);
  wire chip_select_two = cs2_role && pad_addr_reg[15] && in_write;
  wire chip_select_one = cs1_role && pad_addr_reg[14] && in_write;
  wire latch_role = (address_data_multiplex != `PPPS_ADDRESS_DATA_MULTIPLEX_NONE);
  wire addr_latch_high = latch_role && (state_reg == PPPS_LATCH);
  wire addr_latch_low = latch_role && (state_reg == PPPS_LATCH);

  // Pad levels per role
  assign port_address_line_out = {
    cs2_role ? chip_select_two : pad_addr_reg[15],
    cs1_role ? chip_select_one : pad_addr_reg[14],
    pad_addr_reg[13:2],
    latch_role ? addr_latch_high : pad_addr_reg[1],
    latch_role ? addr_latch_low : pad_addr_reg[0]
  };
  assign port_address_line_oe = pin_enable_reg;
  assign general_io_owned = ~pin_enable_reg;
  assign port_write_strobe = in_write;
  assign port_busy = (state_reg != PPPS_IDLE);
  assign port_data_out = data_out_reg;
  assign bus_rdata = rdata_reg;
  assign host_rdata = host_rdata_reg;

  // Configuration registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_enable_reg <= 16'h0000;
      write_target_addr_reg <= 16'h0000;
      raddr_reg <= 16'h0000;
      shared_addr_reg <= 16'h0000;
      control_reg <= 32'h00000000;
      data_out_reg <= 16'h0000;
    end else begin
      if (wr_pin) pin_enable_reg <= bus_req.wdata[15:0];
      if (wr_write_target_addr) write_target_addr_reg <= bus_req.wdata[15:0];
      if (wr_raddr) raddr_reg <= bus_req.wdata[15:0];
      if (wr_shared) shared_addr_reg <= bus_req.wdata[15:0];
      if (wr_control) control_reg <= bus_req.wdata & `PPPS_CONTROL_MASK;
      if (wr_data) data_out_reg <= bus_req.wdata[15:0];
    end
  end

  // Slave flags
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      in_full_reg <= 4'h0;
      out_empty_reg <= `PPPS_OUT_EMPTY_RESET;
      overflow_reg <= 1'b0;
      underflow_reg <= 1'b0;
    end else begin
      in_full_reg <= in_full_next;
      out_empty_reg <= out_empty_next;
      overflow_reg <= overflow_next;
      underflow_reg <= underflow_next;
    end
  end

  // Slave byte buffers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        in_buf_reg[i] <= 8'h00;
        out_buf_reg[i] <= 8'h00;
      end
      host_rdata_reg <= 8'h00;
    end else begin
      if (|host_fill) in_buf_reg[host_req.idx] <= host_req.data;
      if (|sw_out_write) out_buf_reg[buf_idx] <= bus_req.wdata[7:0];
      if (host_rd) host_rdata_reg <= out_buf_reg[host_req.idx];
    end
  end

  // Read data register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) rdata_reg <= 32'h00000000;
    else if (bus_req.rd) rdata_reg <= rdata_next;
  end

  // Master write sequence and pad address
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= PPPS_IDLE;
      pad_addr_reg <= 16'h0000;
    end else begin
      case (state_reg)
        PPPS_IDLE: begin
          if (start_write) begin
            state_reg <= PPPS_LATCH;
            pad_addr_reg <= write_addr_src;
          end else begin
            pad_addr_reg <= idle_addr_src;
          end
        end
        PPPS_LATCH: state_reg <= PPPS_WRITE;
        PPPS_WRITE: state_reg <= PPPS_IDLE;
        default: state_reg <= PPPS_IDLE;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  pad_enable_a: assert property (wr_pin |=> port_address_line_oe == $past(bus_req.wdata[15:0]))
    else $error("pad enable does not follow the enable register");
  pin_upper_a: assert property (bus_req.rd && hit(bus_req.addr, `PPPS_OFF_PIN_ENABLE) |=> bus_rdata[31:16] == 16'h0000)
    else $error("upper pin enable bits read nonzero");
  all_full_a: assert property (status_word[15] == (in_full_reg == 4'hF))
    else $error("all-full flag disagrees with buffer flags");
  overflow_set_a: assert property (overflow_set |=> overflow_reg)
    else $error("overflow not set after write to full buffer");
  read_clear_a: assert property ((sw_in_read != 4'h0) && !host_wr |=> (in_full_reg & $past(sw_in_read)) == 4'h0)
    else $error("input full flag not cleared by read");
  all_empty_a: assert property (status_word[7] == (out_empty_reg == 4'hF))
    else $error("all-empty flag disagrees with buffer flags");
  underflow_set_a: assert property (underflow_set |=> underflow_reg ##1 1'b1)
    else $error("underflow not set after read of empty buffer");
  slave_only_a: assert property (!slave_mode |=> $stable(in_full_reg) || $past(sw_in_read) != 4'h0)
    else $error("input flags changed by host outside slave mode");
  write_seq_a: assert property (start_write |=> state_reg == PPPS_LATCH ##1 port_write_strobe ##1 !port_busy)
    else $error("write sequence timing wrong");
  write_addr_a: assert property (start_write && dual_buffer_enable |=> pad_addr_reg == $past(write_target_addr_reg))
    else $error("write address not taken from write-address register");
  cs_two_a: assert property (in_write && cs2_role |-> port_address_line_out[15] == pad_addr_reg[15])
    else $error("chip select two pad wrong");
  cs_one_a: assert property (!cs1_role |-> port_address_line_out[14] == pad_addr_reg[14])
    else $error("pad 14 not address when chip select one unused");
endmodule : ppps_top

// *** hdl/ppps_params.svh ***
// Offsets, field positions, masks, field codes and reset values for the parallel port pin, status and write-address block
`ifndef PPPS_PARAMS_SVH
`define PPPS_PARAMS_SVH
`define PPPS_OFF_PIN_ENABLE 8'h00
`define PPPS_OFF_STATUS 8'h04
`define PPPS_OFF_WRITE_TARGET_ADDR 8'h08
`define PPPS_OFF_CONTROL 8'h0C
`define PPPS_OFF_RADDR 8'h10
`define PPPS_OFF_SHARED_ADDR 8'h14
`define PPPS_OFF_DATA_OUT 8'h18
`define PPPS_OFF_IN_BUF 8'h20
`define PPPS_OFF_OUT_BUF 8'h30
`define PPPS_BUF_BLOCK_MASK 8'hF0
`define PPPS_CSF_HI 7
`define PPPS_CSF_LO 6
`define PPPS_SLAVE_BIT 8
`define PPPS_SIXTEEN_BIT_WIDTH_BIT 10
`define PPPS_ADDRESS_DATA_MULTIPLEX_HI 12
`define PPPS_ADDRESS_DATA_MULTIPLEX_LO 11
`define PPPS_DUAL_BUFFER_ENABLE_BIT 17
`define PPPS_CONTROL_MASK 32'h00021DC0
`define PPPS_OVF_BIT 14
`define PPPS_UNF_BIT 6
`define PPPS_CSF_ADDR 2'h0
`define PPPS_CSF_CS2 2'h1
`define PPPS_CSF_BOTH 2'h2
`define PPPS_ADDRESS_DATA_MULTIPLEX_NONE 2'h0
`define PPPS_OUT_EMPTY_RESET 4'hF
`endif

// *** hdl/ppps_pkg.sv ***
// Types shared by the parallel port pin, status and write-address block
package ppps_pkg;
  // Register port request from software
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ppps_bus_req_type;
  // Byte access from the external host in slave mode
  typedef struct packed {
    logic wr;
    logic rd;
    logic [1:0] idx;
    logic [7:0] data;
  } ppps_host_req_type;
  // Master write sequence, Gray coded from PPPS_IDLE to PPPS_WRITE; the return to PPPS_IDLE flips both bits
  typedef enum logic [1:0] {
    PPPS_IDLE = 2'b00,
    PPPS_LATCH = 2'b01,
    PPPS_WRITE = 2'b11
  } ppps_state_type;
endpackage : ppps_pkg

// *** bench/ppps_host_model.sv ***
// External host model that drives byte accesses into the slave buffers
`timescale 1ns/1ns
module ppps_host_model (
  input wire logic clock,
  output ppps_pkg::ppps_host_req_type host_req,
  input wire logic [7:0] host_rdata
);
  import ppps_pkg::*;
  // Strobes idle from time zero
  initial host_req = '0;
  // Write one byte into an input buffer, strobe held for one edge
  task automatic put_byte(input logic [1:0] idx, input logic [7:0] data);
    @(posedge clock);
    host_req <= '{wr: 1'b1, rd: 1'b0, idx: idx, data: data};
    @(posedge clock);
    // Released lines show inverted junk, never the last value
    host_req <= '{wr: 1'b0, rd: 1'b0, idx: ~idx, data: ~data};
  endtask : put_byte
  // Read one byte from an output buffer, data taken in the cycle after
  task automatic get_byte(input logic [1:0] idx, output logic [7:0] data);
    @(posedge clock);
    host_req <= '{wr: 1'b0, rd: 1'b1, idx: idx, data: ~host_req.data};
    @(posedge clock);
    host_req <= '{wr: 1'b0, rd: 1'b0, idx: ~idx, data: ~host_req.data};
    #1 data = host_rdata;
  endtask : get_byte
endmodule : ppps_host_model

// *** bench/ppps_top_bench.sv ***
// Self-checking bench for the pad roles, slave status and write addressing
`timescale 1ns/1ns
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module ppps_top_bench;
  import ppps_pkg::*;
  logic clock = 1'b0; // System clock
  logic resetn = 1'b0; // Active-low reset
  ppps_bus_req_type bus_req = '0; // Register port request
  ppps_host_req_type host_req; // Host strobes from the model
  logic [31:0] bus_rdata; // Register read data
  logic [7:0] host_rdata; // Host read data
  logic [15:0] pad_out, pad_oe, gpio_own, data_out; // Pad and data outputs
  logic wstrobe, busy; // Master write progress
  int n_errors = 0; // Mismatches seen
  int check_count = 0; // Comparisons made
  int seed = 49; // Fixed seed keeps runs repeatable
  int cycles = 0; // Hang guard counter
  logic [31:0] rv, pe, wa, ra, d; // Scratch values
  logic [7:0] ob [4]; // Bytes loaded into output buffers
  logic [1:0] chip_select_function; // Chip-select role under test
  logic mux; // Multiplexed address mode under test
  // 100 MHz clock
  always #5 clock = ~clock;
  ppps_top dut (.clock(clock), .resetn(resetn), .bus_req(bus_req), .bus_rdata(bus_rdata), .host_req(host_req),
    .host_rdata(host_rdata), .port_address_line_out(pad_out), .port_address_line_oe(pad_oe),
    .general_io_owned(gpio_own), .port_data_out(data_out), .port_write_strobe(wstrobe), .port_busy(busy));
  ppps_host_model host (.clock(clock), .host_req(host_req), .host_rdata(host_rdata));
  // One-cycle register write
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus_req.wr <= 1'b0;
  endtask : reg_wr
  // One-cycle register read, compared in the cycle after
  task automatic reg_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus_req.rd <= 1'b0;
    #1 `CHK(nm, e, bus_rdata)
  endtask : reg_chk
  // Pads in the latch cycle: chip selects stay low, strobes pulse when multiplexed
  function automatic logic [15:0] latch_pads(input logic [1:0] f, input logic m, input logic [15:0] w);
    return {(f == 2'h1 || f == 2'h2) ? 1'b0 : w[15], (f == 2'h2) ? 1'b0 : w[14], w[13:2], m ? 2'b11 : w[1:0]};
  endfunction : latch_pads
  // Verdict and end of run
  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test
  // Hang guard well above the expected run length
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      finish_test();
    end
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    reg_chk(8'h00, 32'h0, "pin_enable_reset");
    reg_chk(8'h04, 32'h8F, "status_reset");
    reg_chk(8'h08, 32'h0, "write_target_addr_reset");
    reg_chk(8'hFC, 32'h0, "unmapped");
    // Corner and random pad enables
    for (int i = 0; i < 6; i++) begin
      pe = (i == 0) ? 32'hFFFFFFFF : (i == 1) ? 32'h0 : $random(seed);
      reg_wr(8'h00, pe);
      reg_chk(8'h00, {16'h0, pe[15:0]}, "pin_enable");
      `CHK("pad_oe", pe[15:0], pad_oe)
      `CHK("gpio_own", ~pe[15:0], gpio_own)
    end
    reg_wr(8'h08, 32'hFFFFFFFF);
    reg_chk(8'h08, 32'h0000FFFF, "write_target_addr_width");
    host.put_byte(2'h0, 8'h11);
    reg_chk(8'h04, 32'h8F, "status_master");
    // Slave mode: fill inputs, overflow, read back
    reg_wr(8'h0C, 32'h100);
    host.put_byte(2'h1, 8'h5A);
    reg_chk(8'h04, 32'h28F, "one_full");
    for (int i = 0; i < 4; i++) begin
      if (i != 1) begin
        host.put_byte(i[1:0], 8'($random(seed)));
      end
    end
    reg_chk(8'h04, 32'h8F8F, "all_full");
    host.put_byte(2'h1, 8'hC3);
    reg_chk(8'h04, 32'hCF8F, "overflow");
    reg_chk(8'h24, 32'h5A, "in_buf_kept");
    // One buffer drained, so the all-full flag must drop
    reg_chk(8'h04, 32'h4D8F, "read_clears");
    reg_wr(8'h04, 32'h0);
    reg_chk(8'h04, 32'h0D8F, "ovf_clear");
    // Load outputs, drain one, then underflow it
    for (int i = 0; i < 4; i++) begin
      ob[i] = 8'($random(seed));
      reg_wr(8'h30 + 8'(4 * i), {24'h0, ob[i]});
    end
    reg_chk(8'h04, 32'h0D00, "out_loaded");
    host.get_byte(2'h2, rv[7:0]);
    `CHK("host_byte", ob[2], rv[7:0])
    reg_chk(8'h04, 32'h0D04, "one_empty");
    host.get_byte(2'h2, rv[7:0]);
    reg_chk(8'h04, 32'h0D44, "underflow");
    reg_wr(8'h04, 32'h0);
    reg_chk(8'h04, 32'h0D04, "unf_clear");
    // Master mode without dual buffering must not start
    reg_wr(8'h00, 32'hFFFF);
    reg_wr(8'h0C, 32'h0);
    reg_wr(8'h18, 32'h1234);
    #1 `CHK("no_start", 1'b0, busy)
    // Without dual buffering the pads follow the shared address, not the write address
    ra = $random(seed);
    reg_wr(8'h14, ra);
    repeat (2) @(posedge clock);
    #1 `CHK("shared_pads", ra[15:0], pad_out)
    // Dual-buffer writes over every chip-select role, unused role code included, and the multiplexed mode
    for (int k = 0; k < 5; k++) begin
      chip_select_function = 2'(k % 4);
      mux = (k >= 3);
      wa = $random(seed) | 32'hC000;
      ra = $random(seed);
      d = $random(seed);
      reg_wr(8'h0C, 32'h20000 | (32'(mux) << 11) | (32'(chip_select_function) << 6));
      reg_wr(8'h08, wa);
      reg_wr(8'h10, ra);
      repeat (2) @(posedge clock);
      #1 `CHK("idle_pads", ra[13:2], pad_out[13:2])
      reg_wr(8'h18, d);
      #1 `CHK("latch_busy", 1'b1, busy)
      `CHK("latch_pads", latch_pads(chip_select_function, mux, wa[15:0]), pad_out)
      @(posedge clock);
      #1 `CHK("write_strobe", 1'b1, wstrobe)
      `CHK("write_pads", wa[15:2], pad_out[15:2])
      `CHK("write_data", d[15:0], data_out)
      @(posedge clock);
      #1 `CHK("back_idle", 1'b0, busy)
    end
    finish_test();
  end
endmodule : ppps_top_bench
